// >>> common/dcr_pkg.sv
package dcr_pkg;
    // crc generator x^8+x^5+x^3+x^2+x+1, low terms only
    localparam logic [7:0] DCR_CRC_POLY  = 8'h2F;
    localparam logic [7:0] DCR_CRC_SEED  = 8'hFF;
    // opcodes and the global address
    localparam logic [3:0] DCR_OP_READ   = 4'h0;
    localparam logic [3:0] DCR_OP_WRITE  = 4'h8;
    localparam logic [3:0] DCR_OP_COLLECT = 4'hB;
    localparam logic [3:0] DCR_GLOBAL    = 4'h0;
    // command field positions inside the 32-bit frame
    localparam int DCR_ADDR_MSB  = 31;
    localparam int DCR_OP_MSB    = 27;
    localparam int DCR_EXT_MSB   = 23;
    localparam int DCR_REG_MSB   = 15;
    localparam int DCR_CRC_MSB   = 7;
    // frame sizes
    localparam int DCR_FRAME_BITS = 32;
    localparam int DCR_MSG_BITS   = 24;
    localparam int DCR_NIBBLES    = 8;
    localparam logic [5:0] DCR_MSG_LAST = 6'h17;
    localparam logic [5:0] DCR_CRC_LAST = 6'h1F;
    localparam logic [2:0] DCR_NIB_LAST = 3'h7;
    localparam logic [1:0] DCR_CHIP_LAST = 2'h2;
    // chip time
    localparam int DCR_CLK_MHZ     = 25;
    localparam int DCR_CHIP_NS     = 2000;
    localparam int DCR_CHIP_CYC    = (DCR_CHIP_NS * DCR_CLK_MHZ) / 1000;
    // node reset value and node byte register address
    localparam logic [3:0] DCR_NODE_RST  = 4'h0;
    localparam logic [7:0] DCR_NODE_BYTE = 8'h08;
    // chip level codes and response fifo size
    localparam logic [1:0] DCR_LVL_Q  = 2'h0;
    localparam logic [1:0] DCR_LVL_1  = 2'h1;
    localparam logic [1:0] DCR_LVL_2  = 2'h2;
    localparam int DCR_FIFO_W = 32;
    localparam int DCR_FIFO_D = 8;

    typedef enum logic [2:0] {
        DCR_IDLE, DCR_RECV, DCR_CHECK, DCR_ACCESS, DCR_TXCRC, DCR_PUSH
    } dcr_state_t;
endpackage

// >>> logic/dcr_fifo.sv
`timescale 1ns/1ps
module dcr_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } dcr_fifo_ptr_t;
    dcr_fifo_ptr_t    s_r, s_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push, pop;

    // full when pointers differ only in the wrap bit
    assign in_ready  = !((s_r.wp[AW] != s_r.rp[AW]) && (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]));
    assign out_valid = s_r.wp != s_r.rp;
    assign out_data  = mem[s_r.rp[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.wp = s_r.wp + 1'b1;
        end
        if (pop) begin
            s_nxt.rp = s_r.rp + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // storage has no reset, only its pointers
    always_ff @(posedge clk) begin
        if (push) begin
            mem[s_r.wp[AW-1:0]] <= in_data;
        end
    end
endmodule

// >>> logic/dcr_frames.sv
// Contract
// - one master, one slave, register access
// - act only on own node address
// - crc over 32 command bits, msb first
// - bad crc: drop, no response
// - poly 0x2F, seed all ones
// - shift message and crc, zero passes
// - response crc over 32 bits msb first
// - append eight zeros, remainder is crc
// - response: address, opcode, two bytes, crc
// - response echoes received opcode
// - upper byte word+1, lower word+0
// - each nibble one three-chip symbol
// - codes 0,1,2 select current steps
// - fixed sixteen-entry symbol table
// - symbols start non-null, have transition
// - opcodes read 0, write 8, collect B
// - read to other address ignored
// - unreadable register reads as zero
// - global collect locks, switches, no response
`timescale 1ns/1ps
module dcr_frames
    import dcr_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // decoded command bit stream from receiver
    input  wire logic       cmd_start,
    input  wire logic       cmd_bit_valid,
    input  wire logic       cmd_bit,
    // register file access
    output logic            reg_wr,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_readable,
    input  wire logic       reg_writable,
    // node address and mode
    output logic [3:0]      node_address,
    output logic            init_done_lock,
    output logic            periodic_collection_mode,
    // response current drive
    output logic [1:0]      chip_level,
    output logic            resp_active
);
    import dcr_pkg::*;

    // nibble to chip table, three 2-bit codes per entry, first chip high
    function automatic logic [5:0] dcr_symbol(input logic [3:0] nib);
        case (nib)
            4'h0:    dcr_symbol = {DCR_LVL_1, DCR_LVL_1, DCR_LVL_Q};
            4'h1:    dcr_symbol = {DCR_LVL_2, DCR_LVL_1, DCR_LVL_1};
            4'h2:    dcr_symbol = {DCR_LVL_1, DCR_LVL_Q, DCR_LVL_2};
            4'h3:    dcr_symbol = {DCR_LVL_2, DCR_LVL_Q, DCR_LVL_2};
            4'h4:    dcr_symbol = {DCR_LVL_1, DCR_LVL_Q, DCR_LVL_Q};
            4'h5:    dcr_symbol = {DCR_LVL_2, DCR_LVL_1, DCR_LVL_2};
            4'h6:    dcr_symbol = {DCR_LVL_1, DCR_LVL_1, DCR_LVL_2};
            4'h7:    dcr_symbol = {DCR_LVL_2, DCR_LVL_Q, DCR_LVL_1};
            4'h8:    dcr_symbol = {DCR_LVL_2, DCR_LVL_2, DCR_LVL_Q};
            4'h9:    dcr_symbol = {DCR_LVL_2, DCR_LVL_1, DCR_LVL_Q};
            4'hA:    dcr_symbol = {DCR_LVL_1, DCR_LVL_2, DCR_LVL_2};
            4'hB:    dcr_symbol = {DCR_LVL_2, DCR_LVL_2, DCR_LVL_1};
            4'hC:    dcr_symbol = {DCR_LVL_1, DCR_LVL_2, DCR_LVL_Q};
            4'hD:    dcr_symbol = {DCR_LVL_2, DCR_LVL_Q, DCR_LVL_Q};
            4'hE:    dcr_symbol = {DCR_LVL_1, DCR_LVL_Q, DCR_LVL_1};
            default: dcr_symbol = {DCR_LVL_1, DCR_LVL_2, DCR_LVL_1};
        endcase
    endfunction

    // one serial crc step: bit shifts into the low end, shared by check and generate
    function automatic logic [7:0] dcr_crc_step(input logic [7:0] c, input logic b);
        dcr_crc_step = {c[6:0], b} ^ (c[7] ? DCR_CRC_POLY : 8'h00);
    endfunction

    typedef struct packed {
        dcr_state_t  fsm;
        logic [31:0] cmd;
        logic [5:0]  cnt;
        logic [7:0]  crc;
        logic [3:0]  node;
        logic        lock;
        logic        collect;
        logic [1:0]  phase;
        logic [7:0]  lo;
        logic [31:0] resp;
        logic        wr;
        logic        tx_busy;
        logic [31:0] tx_sh;
        logic [2:0]  tx_nib;
        logic [1:0]  tx_chip;
        logic [7:0]  tx_tmr;
        logic [1:0]  lvl;
    } dcr_frm_t;

    dcr_frm_t    s_r, s_nxt;
    logic        f_in_ready, f_out_valid, f_out_ready, f_push;
    logic [31:0] f_out_data;
    logic [3:0]  c_addr, c_op;
    logic [7:0]  c_reg, c_ext;
    logic        addr_hit, glob;
    logic [5:0]  sym;

    assign c_addr   = s_r.cmd[DCR_ADDR_MSB -: 4];
    assign c_op     = s_r.cmd[DCR_OP_MSB -: 4];
    assign c_ext    = s_r.cmd[DCR_EXT_MSB -: 8];
    assign c_reg    = s_r.cmd[DCR_REG_MSB -: 8];
    assign addr_hit = c_addr == s_r.node;
    assign glob     = c_addr == DCR_GLOBAL;
    assign f_push   = s_r.fsm == DCR_PUSH;
    assign f_out_ready = !s_r.tx_busy;

    // register byte fetch; node byte is held here, unreadable reads as zero
    function automatic logic [7:0] rd_byte(input logic [7:0] addr);
        if (addr == DCR_NODE_BYTE) begin
            rd_byte = {4'h0, s_r.node};
        end else begin
            rd_byte = reg_readable ? reg_rdata : 8'h00;
        end
    endfunction

    always_comb begin
        s_nxt    = s_r;
        s_nxt.wr = 1'b0;
        sym      = '0;
        // a new frame start restarts reception in every state except DCR_PUSH
        if (cmd_start && s_r.fsm != DCR_PUSH) begin
            s_nxt.fsm = DCR_RECV;
            s_nxt.cnt = '0;
            s_nxt.crc = DCR_CRC_SEED;
        end else begin
            case (s_r.fsm)
                DCR_RECV: begin
                    if (cmd_bit_valid) begin
                        // message then received crc, msb first
                        s_nxt.cmd = {s_r.cmd[30:0], cmd_bit};
                        s_nxt.crc = dcr_crc_step(s_r.crc, cmd_bit);
                        s_nxt.cnt = s_r.cnt + 6'h01;
                        if (s_r.cnt == DCR_CRC_LAST) begin
                            s_nxt.fsm = DCR_CHECK;
                        end
                    end
                end
                DCR_CHECK: begin
                    s_nxt.fsm   = DCR_IDLE;
                    s_nxt.phase = '0;
                    if (s_r.crc != 8'h00) begin
                        s_nxt.fsm = DCR_IDLE;
                    end else if (c_op == DCR_OP_COLLECT && (addr_hit || glob)) begin
                        s_nxt.lock    = 1'b1;
                        s_nxt.collect = 1'b1;
                        // only an addressed, non-global request is answered
                        if (!glob) begin
                            s_nxt.fsm = DCR_ACCESS;
                        end
                    end else if (c_op == DCR_OP_READ && addr_hit && !glob) begin
                        s_nxt.fsm = DCR_ACCESS;
                    end else if (c_op == DCR_OP_WRITE &&
                                 ((addr_hit && !glob) || (glob && s_r.node == DCR_GLOBAL &&
                                  c_ext == DCR_NODE_BYTE))) begin
                        s_nxt.wr = (c_ext != DCR_NODE_BYTE) && !s_r.lock;
                        if (c_ext == DCR_NODE_BYTE) begin
                            s_nxt.node = c_reg[3:0];
                        end
                        s_nxt.fsm = DCR_ACCESS;
                    end
                    // reserved opcodes fall through to idle
                end
                DCR_ACCESS: begin
                    // phase 0 writes, phase 1 reads word+0, phase 2 reads word+1
                    s_nxt.phase = s_r.phase + 2'h1;
                    if (s_r.phase == 2'h1) begin
                        s_nxt.lo = (c_op == DCR_OP_COLLECT) ? 8'h00 : rd_byte(reg_addr);
                    end else if (s_r.phase == 2'h2) begin
                        s_nxt.resp = {s_r.node, c_op,
                                      (c_op == DCR_OP_COLLECT) ? 8'h00 : rd_byte(reg_addr),
                                      s_r.lo, 8'h00};
                        s_nxt.crc  = DCR_CRC_SEED;
                        s_nxt.cnt  = '0;
                        s_nxt.fsm  = DCR_TXCRC;
                    end
                end
                DCR_TXCRC: begin
                    // 24 message bits then eight zeros
                    s_nxt.crc = dcr_crc_step(s_r.crc, s_r.resp[DCR_CRC_LAST[4:0] - s_r.cnt[4:0]]);
                    s_nxt.cnt = s_r.cnt + 6'h01;
                    if (s_r.cnt == DCR_CRC_LAST) begin
                        s_nxt.fsm = DCR_PUSH;
                    end
                end
                DCR_PUSH: begin
                    s_nxt.resp[DCR_CRC_MSB:0] = s_r.crc;
                    if (f_in_ready) begin
                        s_nxt.fsm = DCR_IDLE;
                    end
                end
                default: s_nxt.fsm = DCR_IDLE;
            endcase
        end
        // symbol transmitter, msb nibble first
        if (!s_r.tx_busy) begin
            if (f_out_valid) begin
                s_nxt.tx_busy = 1'b1;
                s_nxt.tx_sh   = f_out_data;
                s_nxt.tx_nib  = '0;
                s_nxt.tx_chip = '0;
                s_nxt.tx_tmr  = '0;
            end
        end else begin
            s_nxt.tx_tmr = s_r.tx_tmr + 8'h01;
            if (s_r.tx_tmr == 8'(DCR_CHIP_CYC - 1)) begin
                s_nxt.tx_tmr  = '0;
                s_nxt.tx_chip = s_r.tx_chip + 2'h1;
                if (s_r.tx_chip == DCR_CHIP_LAST) begin
                    s_nxt.tx_chip = '0;
                    s_nxt.tx_sh   = {s_r.tx_sh[27:0], 4'h0};
                    s_nxt.tx_nib  = s_r.tx_nib + 3'h1;
                    if (s_r.tx_nib == DCR_NIB_LAST) begin
                        s_nxt.tx_busy = 1'b0;
                    end
                end
            end
        end
        // level taken from the next state so drive and resp_active switch together
        sym       = dcr_symbol(s_nxt.tx_sh[31:28]);
        s_nxt.lvl = s_nxt.tx_busy ? sym[5 - 2*s_nxt.tx_chip -: 2] : DCR_LVL_Q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r      <= '0;
            s_r.fsm  <= DCR_IDLE;
            s_r.node <= DCR_NODE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // register port: byte address from the extended byte, then word+0 and word+1
    always_comb begin
        reg_addr = c_ext;
        if (s_r.fsm == DCR_ACCESS && s_r.phase != 2'h0) begin
            reg_addr = {c_ext[7:1], (s_r.phase == 2'h2)};
        end
    end
    assign reg_wr    = s_r.wr && reg_writable;
    assign reg_wdata = c_reg;

    assign node_address             = s_r.node;
    assign init_done_lock           = s_r.lock;
    assign periodic_collection_mode = s_r.collect;
    assign chip_level               = s_r.lvl;
    assign resp_active              = s_r.tx_busy;

    // responses wait here while the previous one is still on the wire
    dcr_fifo #(
        .WIDTH (DCR_FIFO_W),
        .DEPTH (DCR_FIFO_D)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (f_push),
        .in_ready  (f_in_ready),
        .in_data   ({s_r.resp[31:8], s_r.crc}),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );
endmodule

// >>> tb/dcr_frames_checker.sv
`timescale 1ns/1ps
module dcr_frames_checker
    import dcr_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // command and register side
    input wire logic       cmd_start,
    input wire logic       cmd_bit_valid,
    input wire logic       cmd_bit,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_readable,
    input wire logic       reg_writable,
    // mode and drive
    input wire logic [3:0] node_address,
    input wire logic       init_done_lock,
    input wire logic       periodic_collection_mode,
    input wire logic [1:0] chip_level,
    input wire logic       resp_active
);
    localparam int RESP_CYC = 24 * DCR_CHIP_CYC;
    logic [10:0] act_r;
    logic [11:0] hold_r;
    logic [1:0]  lvl_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // wraps per response so a whole answer ends at zero; queued answers follow after one idle cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            act_r  <= '0;
            hold_r <= '0;
            lvl_r  <= '0;
        end else begin
            act_r  <= (!resp_active || act_r == 11'(RESP_CYC - 1)) ? '0 : act_r + 11'h1;
            hold_r <= (chip_level != lvl_r) ? '0 : hold_r + 12'h1;
            lvl_r  <= chip_level;
        end
    end

    a_idle_quiet: assert property (!resp_active |-> chip_level == DCR_LVL_Q)
        else $error("drive level while idle");
    a_level_legal: assert property (resp_active |-> chip_level != 2'h3)
        else $error("illegal chip level");
    a_first_chip: assert property (
        $rose(resp_active) |-> ##[0:2] chip_level != DCR_LVL_Q)
        else $error("response starts on null chip");
    a_chip_time: assert property (
        resp_active && $past(resp_active) && $past(resp_active, 2) && $changed(chip_level)
        |-> (int'(hold_r) + 1) % DCR_CHIP_CYC == 0)
        else $error("chip width wrong");
    a_resp_length: assert property ($fell(resp_active) |-> act_r == '0)
        else $error("response not whole symbols");
    a_write_pulse: assert property (reg_wr |=> !reg_wr)
        else $error("write strobe held");
    a_lock_sticky: assert property (init_done_lock |=> init_done_lock)
        else $error("lock cleared");
    a_mode_follow: assert property (
        $rose(init_done_lock) |-> ##[0:2] periodic_collection_mode)
        else $error("mode not entered");
    c_resp: cover property ($rose(resp_active));
    c_write: cover property (reg_wr);
    c_lock: cover property ($rose(init_done_lock));
endmodule
bind dcr_frames dcr_frames_checker u_chk (.clk, .rst_n, .cmd_start, .cmd_bit_valid, .cmd_bit,
    .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .reg_readable, .reg_writable, .node_address,
    .init_done_lock, .periodic_collection_mode, .chip_level, .resp_active);

// >>> tb/dcr_master_model.sv
`timescale 1ns/1ps
module dcr_master_model
    import dcr_pkg::*;
(
    // clock
    input  wire logic       clk,
    // command stream
    output logic            cmd_start,
    output logic            cmd_bit_valid,
    output logic            cmd_bit,
    // response current
    input  wire logic [1:0] chip_level,
    input  wire logic       resp_active
);
    // chip triples per nibble, first chip in the top bits
    localparam logic [5:0] SYM [16] = '{6'h14, 6'h25, 6'h12, 6'h22, 6'h10, 6'h26, 6'h16,
        6'h21, 6'h28, 6'h24, 6'h1A, 6'h29, 6'h18, 6'h20, 6'h11, 6'h19};
    logic [31:0] resp_q [$];
    int          bad_sym = 0;

    // idle pins at time zero
    initial begin
        cmd_start = 1'b0;
        cmd_bit_valid = 1'b0;
        cmd_bit = 1'b0;
    end

    // one frame from the single master, msb first
    task automatic send(input logic [31:0] frame);
        @(posedge clk);
        #1 cmd_start = 1'b1;
        @(posedge clk);
        #1 cmd_start = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            cmd_bit_valid = 1'b1;
            cmd_bit = frame[i];
            @(posedge clk);
            #1;
        end
        cmd_bit_valid = 1'b0;
        cmd_bit = ~cmd_bit; // no stale bit left on the line
    endtask

    // sample mid-chip; last wait is short so a queued answer stays aligned
    initial begin
        logic [31:0] word;
        logic [5:0]  sym;
        logic [3:0]  nib;
        logic        hit;
        forever begin
            @(posedge clk);
            if (resp_active === 1'b1) begin
                repeat (DCR_CHIP_CYC / 2) @(posedge clk);
                for (int n = 0; n < 24; n++) begin
                    sym = {sym[3:0], chip_level};
                    if (n % 3 == 2) begin
                        hit = 1'b0;
                        for (int k = 0; k < 16; k++) begin
                            if (SYM[k] === sym) begin
                                nib = 4'(k);
                                hit = 1'b1;
                            end
                        end
                        bad_sym += hit ? 0 : 1;
                        word = {word[27:0], nib};
                    end
                    repeat (n == 23 ? DCR_CHIP_CYC / 2 - 1 : DCR_CHIP_CYC) @(posedge clk);
                end
                resp_q.push_back(word);
            end
        end
    end
endmodule

// >>> tb/dcr_frames_test.sv
`timescale 1ns/1ps
module dcr_frames_test;
    import dcr_pkg::*;
    // clock, reset and block pins
    logic       clk, rst_n, cmd_start, cmd_bit_valid, cmd_bit, reg_wr, reg_readable;
    logic       reg_writable, init_done_lock, periodic_collection_mode, resp_active;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [7:0] regs [256];
    logic [3:0] node_address;
    logic [1:0] chip_level;
    int         bad_count = 0;
    int         total_checks = 0;
    int         cycles = 0;

    dcr_frames dut (.clk, .rst_n, .cmd_start, .cmd_bit_valid, .cmd_bit, .reg_wr, .reg_addr,
        .reg_wdata, .reg_rdata, .reg_readable, .reg_writable, .node_address, .init_done_lock,
        .periodic_collection_mode, .chip_level, .resp_active);
    dcr_master_model m (.clk, .cmd_start, .cmd_bit_valid, .cmd_bit, .chip_level, .resp_active);

    // register file: readable below 40h, writable 10h-1Fh
    assign reg_rdata    = regs[reg_addr];
    assign reg_readable = reg_addr < 8'h40;
    assign reg_writable = reg_addr[7:4] == 4'h1;
    always @(posedge clk) begin
        if (reg_wr === 1'b1) begin
            regs[reg_addr] <= reg_wdata;
        end
    end

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // hang guard, well above the expected run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    // crc seeded all ones, message then eight zeros
    function automatic logic [7:0] crc8(input logic [23:0] msg);
        logic [31:0] w;
        logic [7:0]  c;
        w = {msg, 8'h00};
        c = DCR_CRC_SEED;
        for (int i = 31; i >= 0; i--) begin
            c = {c[6:0], w[i]} ^ (c[7] ? DCR_CRC_POLY : 8'h00);
        end
        return c;
    endfunction

    function automatic logic [31:0] frm(input logic [3:0] a, input logic [3:0] op,
                                        input logic [7:0] e, input logic [7:0] r);
        return {a, op, e, r, crc8({a, op, e, r})};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic exp_resp(input logic [23:0] msg);
        int n;
        logic [31:0] got;
        n = 0;
        while (m.resp_q.size() == 0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        got = m.resp_q.size() > 0 ? m.resp_q.pop_front() : 32'hX;
        check(got, {msg, crc8(msg)});
    endtask

    task automatic exp_none(input logic [31:0] frame);
        m.send(frame);
        repeat (120) @(posedge clk);
        check(m.resp_q.size(), 0);
        check(resp_active, 1'b0);
    endtask

    task automatic t_assign();
        m.send(frm(DCR_GLOBAL, DCR_OP_WRITE, DCR_NODE_BYTE, 8'h05));
        exp_resp({4'h5, DCR_OP_WRITE, regs[8'h09], 8'h05});
        check(node_address, 4'h5);
        $display("test assign done");
    endtask

    task automatic t_rw();
        m.send(frm(4'h5, DCR_OP_READ, 8'h25, 8'h00));
        exp_resp({4'h5, DCR_OP_READ, 8'h7F, 8'h7E});
        m.send(frm(4'h5, DCR_OP_WRITE, 8'h16, 8'hA5));
        exp_resp({4'h5, DCR_OP_WRITE, 8'h4D, 8'hA5});
        check(regs[8'h16], 8'hA5);
        m.send(frm(4'h5, DCR_OP_READ, 8'h80, 8'h00));
        exp_resp({4'h5, DCR_OP_READ, 16'h0000});
        $display("test read write done");
    endtask

    // bad crc, foreign and global read, every reserved opcode
    task automatic t_drop();
        logic [3:0] op;
        exp_none(frm(4'h5, DCR_OP_READ, 8'h24, 8'h00) ^ 32'h1);
        exp_none(frm(4'h3, DCR_OP_READ, 8'h24, 8'h00));
        exp_none(frm(DCR_GLOBAL, DCR_OP_READ, 8'h24, 8'h00));
        for (int k = 1; k < 16; k++) begin
            op = 4'(k);
            if (op != DCR_OP_WRITE && op != DCR_OP_COLLECT) begin
                exp_none(frm(4'h5, op, 8'h16, 8'h00));
            end
        end
        check(regs[8'h16], 8'hA5);
        $display("test drop done");
    endtask

    // reads faster than answers drain, so answers queue up
    task automatic t_burst();
        for (int k = 0; k < 8; k++) begin
            m.send(frm(4'h5, DCR_OP_READ, 8'h20 + 8'(2 * k), 8'h00));
            repeat (50) @(posedge clk);
        end
        for (int k = 0; k < 8; k++) begin
            exp_resp({4'h5, DCR_OP_READ, 8'(8'h21 + 2 * k) ^ 8'h5A, 8'(8'h20 + 2 * k) ^ 8'h5A});
        end
        $display("test burst done");
    endtask

    task automatic t_collect();
        exp_none(frm(DCR_GLOBAL, DCR_OP_COLLECT, 8'h00, 8'h00));
        check(init_done_lock, 1'b1);
        check(periodic_collection_mode, 1'b1);
        $display("test collect done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // reset, then the scenarios in order
    initial begin
        rst_n = 1'b0;
        for (int i = 0; i < 256; i++) begin
            regs[i] = 8'(i) ^ 8'h5A;
        end
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        t_assign();
        t_rw();
        t_drop();
        t_burst();
        t_collect();
        check(m.bad_sym, 0);
        tally_and_finish();
    end
endmodule
